//--- rtl/lacp_pkg.sv
`default_nettype none
package lacp_pkg;

	// Register byte offsets
	localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK   = 32'h0013_33F1;

	// Control field positions
	localparam int CTRL_LEAD_MODE = 0;
	localparam int CTRL_LEAD_SET  = 4;
	localparam int CTRL_FREQ_SEL  = 8;
	localparam int CTRL_SOFT_SEL  = 12;
	localparam int CTRL_WIDTH_SEL = 16;
	localparam int CTRL_SPIN_DIR  = 20;

	// Status field positions
	localparam int STAT_LEAD      = 0;
	localparam int STAT_COMM      = 4;
	localparam int STAT_SOFT      = 8;
	localparam int STAT_HIZ_GAP   = 9;
	localparam int STAT_LIMIT     = 12;
	localparam int STAT_SHUTDOWN  = 13;
	localparam int STAT_OC_STATE  = 14;
	localparam int STAT_SENSORLESS = 16;

	// Three-level select encodings
	localparam logic [1:0] LEVEL_LOW    = 2'h0;
	localparam logic [1:0] LEVEL_MIDDLE = 2'h1;
	localparam logic [1:0] LEVEL_HIGH   = 2'h2;

	// Commutation width codes
	localparam logic [1:0] COMM_120 = 2'h0;
	localparam logic [1:0] COMM_135 = 2'h1;
	localparam logic [1:0] COMM_150 = 2'h2;

	// Lead angle in steps of 3.75 degrees
	localparam logic [3:0] LEAD_STEP_MAX = 4'h8;
	localparam logic [3:0] LEAD_CAP_135  = 4'h6;
	localparam logic [3:0] LEAD_CAP_150  = 4'h4;
	localparam logic [3:0] LEAD_ZERO     = 4'h0;

	// Speed bands in Hz
	localparam logic [11:0] BAND_WIDTH_LOW  = 12'h07D;
	localparam logic [11:0] BAND_WIDTH_HIGH = 12'h0FA;
	localparam int          BAND_COUNT      = 6;

	// Speed-dependent lead, index step*6+band
	localparam logic [3:0] LEAD_TABLE [0:53] = '{
		4'h2, 4'h4, 4'h4, 4'h4, 4'h5, 4'h6,
		4'h0, 4'h2, 4'h4, 4'h4, 4'h5, 4'h6,
		4'h2, 4'h2, 4'h4, 4'h4, 4'h5, 4'h6,
		4'h0, 4'h4, 4'h4, 4'h4, 4'h5, 4'h6,
		4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
		4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
		4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
		4'h1, 4'h3, 4'h5, 4'h7, 4'h8, 4'h8
	};

	// Timing
	localparam int CLK_MHZ      = 20;
	localparam int MASK_TIME_NS = 2400;
	localparam int MASK_CYCLES  = (MASK_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int RESTART_TIME_US = 10000;

	// Overcurrent protection states
	typedef enum logic [1:0] {
		OC_RUN  = 2'b00,
		OC_TRIP = 2'b01,
		OC_WAIT = 2'b10
	} lacp_oc_state_e;

endpackage : lacp_pkg
`default_nettype wire

//--- rtl/lacp_filt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lacp_filt_if;
	logic raw;
	logic hit;
	modport owner  (output raw, input hit);
	modport filter (input raw, output hit);
endinterface : lacp_filt_if
`default_nettype wire

//--- rtl/lacp_mask_filter.sv
`timescale 1ns/1ps
`default_nettype none
module lacp_mask_filter #(
	parameter int HOLD_CYCLES = lacp_pkg::MASK_CYCLES
) (
	// Clock and reset
	input  wire logic     clock,
	input  wire logic     reset,
	// Raw level in, qualified level out
	lacp_filt_if.filter   port_f
);

	localparam int CW = $clog2(HOLD_CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

	logic [CW-1:0] count;
	wire           at_last = (count >= LAST);
	wire  [CW-1:0] next_count = !port_f.raw ? '0 :
	                            at_last ? LAST : count + 1'b1;

	// Counts consecutive high cycles, drops to zero on any gap
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count      <= '0;
			port_f.hit <= 1'b0;
		end else begin
			count      <= next_count;
			port_f.hit <= port_f.raw && at_last;
		end
	end

endmodule : lacp_mask_filter
`default_nettype wire

//--- rtl/lacp_top.sv
// Behaviour
// - Mode high: lead from setting only
// - Mode low: lead follows electrical speed
// - Freq select low: step every 125 Hz
// - Freq select middle/high: step every 250 Hz
// - Six speed bands, width by select
// - 135 degree width caps lead 22.5
// - 150 degree width caps lead 15
// - Selects map to 120/135/150 commutation
// - Soft switching only when select low
// - Forced commutation: 120, zero lead, no soft
// - Current limit turns high side off
// - High side back on at duty turn-on
// - Limit starts on sense comparator flag
// - Limit detections masked for 2.4 us
// - Any of six detectors trips shutdown
// - Detector must persist 2.4 us
// - Shutdown turns all six transistors off
// - Detectors clear, restart wait, restart startup
// - 135 without soft inserts off gap
`timescale 1ns/1ps
`default_nettype none
module lacp_top #(
	parameter int RESTART_CYCLES = lacp_pkg::RESTART_TIME_US * lacp_pkg::CLK_MHZ,
	parameter int MASK_CYCLES    = lacp_pkg::MASK_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Drive state from same-clock logic
	input  wire logic        sensorless_drive,
	input  wire logic        duty_pwm,
	input  wire logic [11:0] elec_freq_hz,
	// Comparator pins
	input  wire logic        sense_over,
	input  wire logic [5:0]  oc_detect,
	// Commutation settings out
	output logic      [3:0]  lead_angle,
	output logic      [1:0]  comm_width,
	output logic             soft_switch_en,
	output logic             hiz_gap_en,
	output logic             spin_reverse,
	// Power stage control out
	output logic             high_side_allow,
	output logic             outputs_off,
	output logic             overcurrent_shutdown,
	output logic             startup_restart
);

	localparam int RCW = $clog2(RESTART_CYCLES + 1);
	localparam logic [RCW-1:0] RESTART_LAST = RCW'(RESTART_CYCLES - 1);

	// Pin synchronisers; logic reads only the second flop
	logic       sense_meta;
	logic       sense_sync;
	wire  [5:0] oc_sync;

	// Current sense comparator, two flops
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sense_meta <= 1'b0;
			sense_sync <= 1'b0;
		end else begin
			sense_meta <= sense_over;
			sense_sync <= sense_meta;
		end
	end

	// One two-flop synchroniser per transistor detector
	genvar j;
	generate
		for (j = 0; j < 6; j++) begin : g_oc_sync
			logic meta;
			logic sync;

			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					meta <= 1'b0;
					sync <= 1'b0;
				end else begin
					meta <= oc_detect[j];
					sync <= meta;
				end
			end

			assign oc_sync[j] = sync;
		end
	endgenerate

	// AHB-Lite address phase decode
	logic        ctrl_wr_pending;
	logic [31:0] ctrl;
	logic [31:0] status;
	wire         bus_take  = hsel && htrans[1] && hready;
	wire         hit_ctrl  = (haddr == lacp_pkg::ADDR_CTRL);
	wire         hit_stat  = (haddr == lacp_pkg::ADDR_STATUS);
	wire         take_wr   = bus_take && hwrite && hit_ctrl;
	wire         take_rd   = bus_take && !hwrite;
	wire  [31:0] rd_value  = hit_ctrl ? ctrl :
	                         hit_stat ? status : 32'h0000_0000;

	// Bus handshake, zero wait states, always OKAY
	// Read data is zero outside its one data phase
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			hreadyout       <= 1'b1;
			hresp           <= 1'b0;
			hrdata          <= 32'h0000_0000;
			ctrl_wr_pending <= 1'b0;
		end else begin
			hreadyout       <= 1'b1;
			hresp           <= 1'b0;
			hrdata          <= take_rd ? rd_value : 32'h0000_0000;
			ctrl_wr_pending <= take_wr;
		end
	end

	// Control register written in data phase
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl <= lacp_pkg::CTRL_RESET;
		end else if (ctrl_wr_pending) begin
			ctrl <= hwdata & lacp_pkg::CTRL_MASK;
		end
	end

	// Control fields
	wire       lead_mode_select = ctrl[lacp_pkg::CTRL_LEAD_MODE];
	wire [3:0] lead_angle_setting = ctrl[lacp_pkg::CTRL_LEAD_SET +: 4];
	wire [1:0] forced_comm_freq_select = ctrl[lacp_pkg::CTRL_FREQ_SEL +: 2];
	wire       soft_switch_select = ctrl[lacp_pkg::CTRL_SOFT_SEL];
	wire [1:0] commutation_width_select =
	           ctrl[lacp_pkg::CTRL_WIDTH_SEL +: 2];
	wire       spin_direction_select = ctrl[lacp_pkg::CTRL_SPIN_DIR];

	// Speed band from thermometer of thresholds
	// Speeds past the last threshold stay in the top band
	wire [11:0] band_width =
	            (forced_comm_freq_select == lacp_pkg::LEVEL_LOW) ?
	            lacp_pkg::BAND_WIDTH_LOW :
	            lacp_pkg::BAND_WIDTH_HIGH;
	wire [lacp_pkg::BAND_COUNT-2:0] band_over;

	genvar k;
	generate
		for (k = 1; k < lacp_pkg::BAND_COUNT; k++) begin : g_band
			assign band_over[k-1] = (elec_freq_hz >= band_width * 12'(k));
		end
	endgenerate

	wire [2:0] speed_band = 3'(band_over[0]) + 3'(band_over[1]) +
	                        3'(band_over[2]) + 3'(band_over[3]) +
	                        3'(band_over[4]);

	// Setting decoded to nine steps
	// Codes above eight clamp to the top step
	wire [3:0] lead_step = (lead_angle_setting > lacp_pkg::LEAD_STEP_MAX) ?
	                       lacp_pkg::LEAD_STEP_MAX :
	                       lead_angle_setting;
	wire [5:0] table_index = 6'(lead_step) * 6'h06 + 6'(speed_band);
	wire [3:0] speed_lead  = lacp_pkg::LEAD_TABLE[table_index];
	wire [3:0] raw_lead    = lead_mode_select ?
	                         lead_step :
	                         speed_lead;

	// Commutation width from both selects
	wire [1:0] width_soft_on =
	           (commutation_width_select == lacp_pkg::LEVEL_MIDDLE) ?
	           lacp_pkg::COMM_135 : lacp_pkg::COMM_150;
	wire [1:0] width_soft_off =
	           (commutation_width_select == lacp_pkg::LEVEL_MIDDLE) ?
	           lacp_pkg::COMM_135 :
	           (commutation_width_select == lacp_pkg::LEVEL_LOW) ?
	           lacp_pkg::COMM_150 : lacp_pkg::COMM_120;
	wire [1:0] sel_width = soft_switch_select ? width_soft_off :
	                       width_soft_on;

	// Lead clamped to width limit
	wire [3:0] lead_cap = (sel_width == lacp_pkg::COMM_135) ?
	                      lacp_pkg::LEAD_CAP_135 :
	                      (sel_width == lacp_pkg::COMM_150) ?
	                      lacp_pkg::LEAD_CAP_150 :
	                      lacp_pkg::LEAD_STEP_MAX;
	wire [3:0] capped_lead = (raw_lead > lead_cap) ? lead_cap : raw_lead;

	// Startup forced commutation overrides settings
	// Safe settings hold until sensorless drive begins
	wire [3:0] next_lead  = sensorless_drive ? capped_lead :
	                        lacp_pkg::LEAD_ZERO;
	wire [1:0] next_width = sensorless_drive ? sel_width :
	                        lacp_pkg::COMM_120;
	wire       next_soft  = sensorless_drive &&
	                        !soft_switch_select;
	wire       next_gap   = (next_width == lacp_pkg::COMM_135) &&
	                        !next_soft;

	// Registered commutation settings
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lead_angle     <= lacp_pkg::LEAD_ZERO;
			comm_width     <= lacp_pkg::COMM_120;
			soft_switch_en <= 1'b0;
			hiz_gap_en     <= 1'b0;
			spin_reverse   <= 1'b0;
		end else begin
			lead_angle     <= next_lead;
			comm_width     <= next_width;
			soft_switch_en <= next_soft;
			hiz_gap_en     <= next_gap;
			spin_reverse   <= spin_direction_select;
		end
	end

	// Noise masks for both comparators
	// A level must persist for the whole mask time to count
	lacp_filt_if limit_f ();
	lacp_filt_if oc_f ();

	assign limit_f.raw = sense_sync;
	assign oc_f.raw    = |oc_sync;

	lacp_mask_filter #(
		.HOLD_CYCLES (MASK_CYCLES)
	) u_limit_mask (
		.clock  (clock),
		.reset  (reset),
		.port_f (limit_f)
	);

	lacp_mask_filter #(
		.HOLD_CYCLES (MASK_CYCLES)
	) u_oc_mask (
		.clock  (clock),
		.reset  (reset),
		.port_f (oc_f)
	);

	// Current limit latch, set wins over duty edge clear
	// A detection on the same cycle as a duty edge keeps it set
	logic limit_active;
	logic duty_prev;
	wire  duty_rise  = duty_pwm && !duty_prev;
	wire  next_limit = limit_f.hit ? 1'b1 :
	                   duty_rise ? 1'b0 :
	                   limit_active;

	// Overcurrent shutdown and restart sequencing
	// Restart timer runs only in the wait state with all clear
	lacp_pkg::lacp_oc_state_e oc_state;
	lacp_pkg::lacp_oc_state_e next_oc_state;
	logic [RCW-1:0]           restart_count;
	wire                      any_oc = |oc_sync;
	wire                      wait_done = (restart_count == RESTART_LAST);
	wire [RCW-1:0]            next_restart_count =
	                          (oc_state != lacp_pkg::OC_WAIT || any_oc) ?
	                          '0 : restart_count + 1'b1;

	always_comb begin
		next_oc_state = oc_state;
		unique case (oc_state)
			lacp_pkg::OC_RUN: begin
				if (oc_f.hit) begin
					next_oc_state = lacp_pkg::OC_TRIP;
				end
			end
			lacp_pkg::OC_TRIP: begin
				if (!any_oc) begin
					next_oc_state = lacp_pkg::OC_WAIT;
				end
			end
			lacp_pkg::OC_WAIT: begin
				if (any_oc) begin
					next_oc_state = lacp_pkg::OC_TRIP;
				end else if (wait_done) begin
					next_oc_state = lacp_pkg::OC_RUN;
				end
			end
			default: begin
				next_oc_state = lacp_pkg::OC_TRIP;
			end
		endcase
	end

	wire next_off     = (next_oc_state != lacp_pkg::OC_RUN);
	wire next_restart = (oc_state == lacp_pkg::OC_WAIT) &&
	                    (next_oc_state == lacp_pkg::OC_RUN);

	// Protection state, restart timer and limit latch
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			oc_state      <= lacp_pkg::OC_RUN;
			restart_count <= '0;
			limit_active  <= 1'b0;
			duty_prev     <= 1'b0;
		end else begin
			oc_state      <= next_oc_state;
			restart_count <= next_restart_count;
			limit_active  <= next_limit;
			duty_prev     <= duty_pwm;
		end
	end

	// Power stage gating, registered straight to the pins
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			high_side_allow      <= 1'b0;
			outputs_off          <= 1'b0;
			overcurrent_shutdown <= 1'b0;
			startup_restart      <= 1'b0;
		end else begin
			high_side_allow      <= !next_limit && !next_off;
			outputs_off          <= next_off;
			overcurrent_shutdown <= next_off;
			startup_restart      <= next_restart;
		end
	end

	// Status view of the block's own state
	assign status = {15'h0000,
	                 sensorless_drive,
	                 oc_state,
	                 overcurrent_shutdown,
	                 limit_active,
	                 2'h0,
	                 hiz_gap_en,
	                 soft_switch_en,
	                 2'h0,
	                 comm_width,
	                 lead_angle};

endmodule : lacp_top
`default_nettype wire

//--- testbench/lacp_props.sv
`timescale 1ns/1ps
`default_nettype none
module lacp_props_chk (
	// Clock and reset
	input wire logic       clock,
	input wire logic       reset,
	// Drive inputs
	input wire logic       sensorless_drive,
	input wire logic       duty_pwm,
	input wire logic [5:0] oc_detect,
	// Settings and power stage outputs
	input wire logic [3:0] lead_angle,
	input wire logic [1:0] comm_width,
	input wire logic       soft_switch_en,
	input wire logic       hiz_gap_en,
	input wire logic       high_side_allow,
	input wire logic       outputs_off,
	input wire logic       overcurrent_shutdown,
	input wire logic       startup_restart
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// Restart pulse gone one cycle later
	sequence s_drop;
		!startup_restart;
	endsequence
	// Commutation settings
	forced_mode_a:
		assert property (!sensorless_drive |=> lead_angle == 4'h0
			&& comm_width == lacp_pkg::COMM_120 && !soft_switch_en)
		else $error("forced mode settings wrong");
	cap_135_a:
		assert property (comm_width == lacp_pkg::COMM_135 |-> lead_angle <= 4'h6)
		else $error("lead above cap at 135");
	cap_150_a:
		assert property (comm_width == lacp_pkg::COMM_150 |-> lead_angle <= 4'h4)
		else $error("lead above cap at 150");
	hiz_gap_a:
		assert property (hiz_gap_en == (comm_width == lacp_pkg::COMM_135
			&& !soft_switch_en))
		else $error("off gap flag wrong");
	soft_width_a:
		assert property (soft_switch_en |-> comm_width != lacp_pkg::COMM_120)
		else $error("soft switching at 120");
	// Protection
	shutdown_off_a:
		assert property (outputs_off && $past(outputs_off)
			|-> !high_side_allow && overcurrent_shutdown)
		else $error("high side on in shutdown");
	oc_persist_a:
		assert property ($rose(outputs_off)
			|-> $past(oc_detect, 3) != 6'h00
			&& $past(oc_detect, 4) != 6'h00
			&& $past(oc_detect, 5) != 6'h00
			&& $past(oc_detect, 6) != 6'h00)
		else $error("shutdown without lasting detection");
	restart_pulse_a:
		assert property (startup_restart
			|-> ($past(outputs_off) && !outputs_off) ##1 s_drop)
		else $error("restart pulse wrong");
	limit_release_a:
		assert property ($rose(high_side_allow) && !$past(reset)
			&& !$past(reset, 2)
			&& !$past(outputs_off) && !$past(outputs_off, 2)
			|-> $past(duty_pwm) || $past(duty_pwm, 2))
		else $error("high side back on without duty edge");
endmodule : lacp_props_chk
bind lacp_top lacp_props_chk chk (.clock, .reset, .sensorless_drive,
	.duty_pwm, .oc_detect, .lead_angle, .comm_width, .soft_switch_en,
	.hiz_gap_en, .high_side_allow, .outputs_off, .overcurrent_shutdown,
	.startup_restart);
`default_nettype wire

//--- testbench/lacp_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module lacp_stage_model (
	// Gate controls from the block
	input  wire logic       high_side_allow,
	input  wire logic       outputs_off,
	// Faults commanded by the bench
	input  wire logic       short_load,
	input  wire logic [5:0] short_fet,
	// Comparator flags
	output logic            sense_over,
	output logic [5:0]      oc_detect
);
	// Current flows only through transistors switched on
	assign sense_over = short_load & high_side_allow & ~outputs_off;
	assign oc_detect  = short_fet & {6{~outputs_off}};
endmodule : lacp_stage_model
`default_nettype wire

//--- testbench/lacp_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lacp_bench;
	localparam int MC = 4;
	localparam int RC = 20;
	localparam logic [11:0] FREQ [0:9] = '{12'h000, 12'h07C, 12'h07D,
		12'h0F9, 12'h0FA, 12'h270, 12'h271, 12'h4E1, 12'h4E2, 12'hFA0};
	// Bench-driven inputs
	logic        clock, reset, hsel, hwrite, sensorless_drive, duty_pwm;
	logic        short_load;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [11:0] elec_freq_hz;
	logic [5:0]  short_fet;
	// Block and stage model outputs
	wire logic        hready, sense_over, soft_switch_en, hiz_gap_en;
	wire logic        high_side_allow, outputs_off;
	wire logic        overcurrent_shutdown, startup_restart;
	wire logic        hresp, spin_reverse;
	wire logic [31:0] hrdata;
	wire logic [5:0]  oc_detect;
	wire logic [3:0]  lead_angle;
	wire logic [1:0]  comm_width;
	int          mismatches, compares;

	lacp_top #(.RESTART_CYCLES(RC), .MASK_CYCLES(MC)) dut (.clock, .reset,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.hreadyout(hready), .hresp, .hrdata, .sensorless_drive,
		.duty_pwm, .elec_freq_hz, .sense_over, .oc_detect, .lead_angle,
		.comm_width, .soft_switch_en, .hiz_gap_en, .spin_reverse,
		.high_side_allow, .outputs_off, .overcurrent_shutdown,
		.startup_restart);
	lacp_stage_model stage (.high_side_allow, .outputs_off, .short_load,
		.short_fet, .sense_over, .oc_detect);

	// Clock
	always #25 clock = ~clock;

	task automatic finish_test;
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task automatic give_up;
		mismatches++;
		finish_test();
	endtask : give_up

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	// One single AHB transfer, waits bounded
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clock);
			n++;
		end while (hready !== 1'b1 && n < 40);
		q = hrdata;
		if (n >= 40) give_up();
	endtask : bus

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask : rd

	task automatic setup(input logic [31:0] c, input logic sd);
		logic [31:0] q;
		sensorless_drive <= sd;
		bus(1'b1, lacp_pkg::ADDR_CTRL, c, q);
		repeat (2) @(posedge clock);
	endtask : setup

	function automatic logic [31:0] cw(input logic m, input logic [3:0] s,
		input logic [1:0] fs, input logic sf, input logic [1:0] w);
		return {14'h0, w, 3'h0, sf, 2'h0, fs, s, 3'h0, m};
	endfunction : cw

	task automatic t_regs;
		rd(lacp_pkg::ADDR_CTRL, lacp_pkg::CTRL_RESET);
		check(32'({spin_reverse, hresp}), 32'h0);
		setup(32'hFFFF_FFFF, 1'b1);
		check(32'({spin_reverse, hresp}), 32'h2);
		rd(lacp_pkg::ADDR_CTRL, lacp_pkg::CTRL_MASK);
		rd(lacp_pkg::ADDR_STATUS, 32'h0001_0008);
		rd(32'h0000_0008, 32'h0);
	endtask : t_regs

	task automatic t_map;
		logic [1:0] e;
		for (int s = 0; s < 2; s++) begin
			for (int w = 0; w < 3; w++) begin
				setup(cw(1'b1, 4'h0, 2'h0, 1'(s), 2'(w)), 1'b1);
				e = (w == 1) ? lacp_pkg::COMM_135 : (s == 1 && w == 2) ?
					lacp_pkg::COMM_120 : lacp_pkg::COMM_150;
				check(32'({comm_width, soft_switch_en, hiz_gap_en}),
					32'({e, s == 0, s == 1 && w == 1}));
			end
		end
	endtask : t_map

	task automatic t_fixed;
		for (int s = 0; s < 10; s++) begin
			elec_freq_hz <= 12'(s) * 12'h0C8;
			setup(cw(1'b1, 4'(s), 2'h0, 1'b1, 2'h2), 1'b1);
			check(32'(lead_angle), (s > 8) ? 32'h8 : 32'(s));
		end
		setup(cw(1'b1, 4'h8, 2'h0, 1'b1, 2'h1), 1'b1);
		check(32'(lead_angle), 32'h6);
		setup(cw(1'b1, 4'h8, 2'h0, 1'b1, 2'h0), 1'b1);
		check(32'(lead_angle), 32'h4);
	endtask : t_fixed

	task automatic t_speed;
		int w;
		int b;
		for (int fs = 0; fs < 4; fs++) begin
			w = (fs == 0) ? int'(lacp_pkg::BAND_WIDTH_LOW) :
				int'(lacp_pkg::BAND_WIDTH_HIGH);
			for (int s = 0; s < 9; s++) begin
				setup(cw(1'b0, 4'(s), 2'(fs), 1'b1, 2'h2), 1'b1);
				for (int i = 0; i < 10; i++) begin
					elec_freq_hz <= FREQ[i];
					repeat (2) @(posedge clock);
					b = 0;
					for (int k = 1; k < 6; k++) b += int'(FREQ[i] >= k * w);
					check(32'(lead_angle),
						32'(lacp_pkg::LEAD_TABLE[s * 6 + b]));
				end
			end
		end
	endtask : t_speed

	task automatic t_forced;
		setup(cw(1'b1, 4'h8, 2'h0, 1'b0, 2'h1), 1'b0);
		check(32'({lead_angle, comm_width, soft_switch_en}), 32'h0);
		sensorless_drive <= 1'b1;
		repeat (2) @(posedge clock);
		check(32'({lead_angle, comm_width, soft_switch_en}),
			32'({4'h6, lacp_pkg::COMM_135, 1'b1}));
	endtask : t_forced

	task automatic t_limit;
		int n;
		short_load <= 1'b1;
		repeat (MC - 1) @(posedge clock);
		short_load <= 1'b0;
		repeat (8) @(posedge clock);
		check(32'(high_side_allow), 32'h1);
		short_load <= 1'b1;
		n = 0;
		while (high_side_allow !== 1'b0 && n < MC + 8) begin
			@(posedge clock);
			n++;
		end
		if (n >= MC + 8) give_up();
		check(32'(n), 32'(MC + 4));
		short_load <= 1'b0;
		repeat (6) @(posedge clock);
		check(32'({high_side_allow, outputs_off}), 32'h0);
		duty_pwm <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'(high_side_allow), 32'h1);
		duty_pwm <= 1'b0;
	endtask : t_limit

	task automatic t_oc;
		int n;
		for (int b = 0; b < 6; b++) begin
			short_fet <= 6'h01 << b;
			repeat (MC - 1) @(posedge clock);
			short_fet <= 6'h00;
			repeat (6) @(posedge clock);
			check(32'(outputs_off), 32'h0);
			short_fet <= 6'h01 << b;
			n = 0;
			while (outputs_off !== 1'b1 && n < MC + 10) begin
				@(posedge clock);
				n++;
			end
			if (n >= MC + 10) give_up();
			@(posedge clock);
			check(32'({overcurrent_shutdown, high_side_allow}), 32'h2);
			short_fet <= 6'h00;
			n = 0;
			while (startup_restart !== 1'b1 && n < RC + 20) begin
				@(posedge clock);
				n++;
			end
			if (n >= RC + 20) give_up();
			check(32'({n == RC + 2, outputs_off}), 32'h2);
		end
	endtask : t_oc

	// Main sequence
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		sensorless_drive = 1'b0;
		duty_pwm = 1'b0;
		elec_freq_hz = 12'h000;
		short_load = 1'b0;
		short_fet = 6'h00;
		mismatches = 0;
		compares = 0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		t_regs();
		t_map();
		t_fixed();
		t_speed();
		t_forced();
		t_limit();
		t_oc();
		finish_test();
	end
endmodule : lacp_bench
`default_nettype wire
